/* hdl/gpib_message_status_unit.sv */
`timescale 1ns/1ps

// How it works
// - remote enable line puts device into remote
// - interface clear abandons any transfer in progress
// - local lockout locks out front panel controls
// - device clear resets interface activity to idle
// - addressed commands need our listen address first
// - addressed go-to-local leaves remote mode
// - serial poll enable sends status byte when talking
// - semicolon splits chained command strings
// - mnemonic, query mark, space, data, terminator
// - responses only sent once talk addressed
// - only the latest query gets answered
// - bit 7 ramp done; bits 1,2 zero
// - bit 5 set by standard event status
// - bit 4 instrument error, bit 3 alarm
// - bit 0 set on fresh input readings
// - service request pulled low on enabled bits
// - enable bit 6 gates service request
// - serial poll clears the reported bits
// - status query reads without clearing
// - enable bit one enables, zero inhibits
// - selectable terminators, carriage return line feed default
// - bus address 1 to 30, default 12
module gpib_message_status_unit (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic ATN_N_I,
  input wire logic REN_N_I,
  input wire logic IFC_N_I,
  input wire logic EOI_N_I,
  output logic EOI_N_O,
  output logic EOI_N_OE_N,
  input wire logic DAV_N_I,
  output logic DAV_N_O,
  output logic DAV_N_OE_N,
  input wire logic NRFD_N_I,
  output logic NRFD_N_O,
  output logic NRFD_N_OE_N,
  input wire logic NDAC_N_I,
  output logic NDAC_N_O,
  output logic NDAC_N_OE_N,
  input wire logic [7:0] DIO_N_I,
  output logic [7:0] DIO_N_O,
  output logic [7:0] DIO_N_OE_N,
  output logic SRQ_N_O,
  output logic SRQ_N_OE_N,
  input wire logic CFG_WR,
  input wire logic [4:0] CFG_ADDR,
  input wire gpib_msu_pkg::term_t CFG_TERM,
  input wire logic SRE_WR,
  input wire logic [7:0] SRE_DATA,
  input wire gpib_msu_pkg::status_events_t STATUS_EVENTS,
  input wire logic [7:0] RESP_DATA,
  input wire logic RESP_VALID,
  input wire logic RESP_LAST,
  output logic RESP_TAKE,
  output logic [7:0] MSG_DATA,
  output logic MSG_VALID,
  output logic MSG_SEP,
  output logic MSG_QUERY,
  output logic MSG_END,
  output logic MSG_ERR,
  output logic REMOTE,
  output logic PANEL_LOCKED,
  output logic LISTENING,
  output logic TALKING,
  output logic [4:0] BUS_ADDR,
  output logic [7:0] STATUS_BYTE,
  output logic [7:0] SRE_VALUE
);
  import gpib_msu_pkg::*;

  typedef struct packed {
    bus_sample_t s1;
    bus_sample_t s2;
    logic ren_seen;
    ah_t ah;
    sh_t sh;
    logic remote;
    logic lockout;
    logic listen;
    logic talk;
    logic spe;
    logic polled;
    logic [4:0] addr;
    term_t term;
    logic [7:0] stb;
    logic [7:0] sre;
    logic [6:0] len;
    logic term2;
    logic seg_any;
    logic seg_space;
    logic seg_query;
    logic xfer_query;
    logic query_pend;
    logic [7:0] tx_byte;
    logic tx_eoi;
    logic tx_poll;
    logic [7:0] msg_data;
    logic msg_valid;
    logic msg_sep;
    logic msg_query;
    logic msg_end;
    logic msg_err;
    logic resp_take;
    logic [7:0] dio_oe_n;
    logic dav_oe_n;
    logic eoi_oe_n;
    logic nrfd_oe_n;
    logic ndac_oe_n;
    logic srq_oe_n;
    logic [7:0] stb_out;
  } state_t;

  state_t q;
  state_t n;

  // abandon interface activity; ifc also unaddresses and restarts acceptor
  function automatic state_t clear_io(input state_t s, input logic is_ifc);
    state_t r;
    r = s;
    r.len = 7'h00;
    r.term2 = 1'b0;
    r.seg_any = 1'b0;
    r.seg_space = 1'b0;
    r.seg_query = 1'b0;
    r.xfer_query = 1'b0;
    r.query_pend = 1'b0;
    r.sh = SH_IDLE;
    r.dio_oe_n = 8'hFF;
    r.dav_oe_n = 1'b1;
    r.eoi_oe_n = 1'b1;
    if (is_ifc) begin
      r.listen = 1'b0;
      r.talk = 1'b0;
      r.spe = 1'b0;
      r.ah = AH_READY;
      r.nrfd_oe_n = 1'b1;
      r.ndac_oe_n = 1'b1;
    end else begin
      r.stb = STB_RESET;
    end
    return r;
  endfunction

  logic atn;
  logic dav;
  logic eoi;
  logic active;
  logic talk_act;
  logic got;
  logic sep_now;
  logic end_now;
  logic last_query;
  logic rqs;
  logic [7:0] rx;
  logic [7:0] second;

  always_comb begin
    n = q;
    n.s1 = '{ATN_N_I, REN_N_I, IFC_N_I, EOI_N_I, DAV_N_I, NRFD_N_I, NDAC_N_I, DIO_N_I};
    n.s2 = q.s1;
    n.msg_valid = 1'b0;
    n.msg_sep = 1'b0;
    n.msg_query = 1'b0;
    n.msg_end = 1'b0;
    n.msg_err = 1'b0;
    n.resp_take = 1'b0;
    atn = ~q.s2.atn_n;
    dav = ~q.s2.dav_n;
    eoi = ~q.s2.eoi_n;
    rx = ~q.s2.dio_n;
    got = 1'b0;
    sep_now = 1'b0;
    end_now = 1'b0;
    last_query = 1'b0;
    second = (q.term == TERM_CRLF) ? CHAR_LF : CHAR_CR;

    n.ren_seen = ~q.s2.ren_n;
    if (n.ren_seen && !q.ren_seen) begin
      n.remote = 1'b1;
    end
    if (!n.ren_seen) begin
      n.remote = 1'b0;
      n.lockout = 1'b0;
    end

    if (CFG_WR) begin
      if (CFG_ADDR >= ADDR_MIN && CFG_ADDR <= ADDR_MAX) begin
        n.addr = CFG_ADDR;
      end
      n.term = CFG_TERM;
    end
    if (SRE_WR) begin
      n.sre = SRE_DATA;
    end

    // acceptor handshake: all devices during attention, listener otherwise
    active = atn || q.listen;
    case (q.ah)
      AH_READY: begin
        // ready for data: nrfd released, ndac held low while taking part
        n.nrfd_oe_n = 1'b1;
        n.ndac_oe_n = ~active;
        if (active && dav) begin
          got = 1'b1;
          n.nrfd_oe_n = 1'b0;
          n.ah = AH_ACCEPT;
        end
      end
      AH_ACCEPT: begin
        n.ndac_oe_n = 1'b1;
        n.ah = AH_WAIT_DAV_HIGH;
      end
      AH_WAIT_DAV_HIGH: begin
        if (!dav) begin
          n.ndac_oe_n = 1'b0;
          n.nrfd_oe_n = 1'b1;
          n.ah = AH_READY;
        end
      end
      default: n.ah = AH_READY;
    endcase

    // command bytes are only those taken with attention low
    if (got && atn) begin
      if (rx[6:5] == GRP_LISTEN) begin
        if (rx[6:0] == CMD_UNL) begin
          n.listen = 1'b0;
        end else if (rx[4:0] == q.addr) begin
          n.listen = 1'b1;
          n.talk = 1'b0;
        end
      end else if (rx[6:5] == GRP_TALK) begin
        if (rx[6:0] == CMD_UNT) begin
          n.talk = 1'b0;
        end else if (rx[4:0] == q.addr) begin
          n.talk = 1'b1;
          n.listen = 1'b0;
          n.polled = 1'b0;
        end else begin
          n.talk = 1'b0;
        end
      end else begin
        case (rx[6:0])
          CMD_LLO: n.lockout = 1'b1;
          CMD_DCL: n = clear_io(n, 1'b0);
          CMD_SDC: if (q.listen) n = clear_io(n, 1'b0);
          CMD_GTL: if (q.listen) n.remote = 1'b0;
          CMD_SPE: n.spe = 1'b1;
          CMD_SPD: n.spe = 1'b0;
          default: n.spe = n.spe;
        endcase
      end
    end

    // message string checker
    if (got && !atn && q.listen) begin
      if (q.term2) begin
        n.term2 = 1'b0;
        if (rx != second) begin
          n.msg_err = 1'b1;
        end
      end else if ((q.term == TERM_CRLF && rx == CHAR_CR) ||
                   (q.term == TERM_LFCR && rx == CHAR_LF) ||
                   (q.term == TERM_LF && rx == CHAR_LF)) begin
        end_now = 1'b1;
        n.term2 = (q.term != TERM_LF);
      end else begin
        n.len = q.len + 7'h01;
        if (q.len >= MSG_MAX_LEN) begin
          n.msg_err = 1'b1;
        end
        if (rx == CHAR_SEMI) begin
          sep_now = 1'b1;
        end else begin
          n.msg_data = rx;
          n.msg_valid = 1'b1;
          if (rx == CHAR_QMARK) begin
            if (q.seg_space || !q.seg_any || q.xfer_query) begin
              n.msg_err = 1'b1;
            end
            n.seg_query = 1'b1;
            n.xfer_query = 1'b1;
          end else if (rx == CHAR_SPACE) begin
            if (!q.seg_any) begin
              n.msg_err = 1'b1;
            end
            n.seg_space = 1'b1;
          end else begin
            n.seg_any = 1'b1;
          end
        end
        if (q.term == TERM_EOI && eoi) begin
          end_now = 1'b1;
        end
      end
      if (sep_now || end_now) begin
        last_query = n.seg_query;
        n.msg_sep = 1'b1;
        n.msg_query = last_query;
        if (!n.seg_any || (last_query && sep_now)) begin
          n.msg_err = 1'b1;
        end
        n.seg_any = 1'b0;
        n.seg_space = 1'b0;
        n.seg_query = 1'b0;
      end
      if (end_now) begin
        n.msg_end = 1'b1;
        n.len = 7'h00;
        n.xfer_query = 1'b0;
        if (last_query) begin
          n.query_pend = 1'b1;
        end
      end
    end

    // source handshake, only while talk addressed and attention high
    talk_act = q.talk && !atn;
    case (q.sh)
      SH_IDLE: begin
        if (talk_act && q.spe && !q.polled) begin
          n.tx_byte = q.stb_out;
          n.tx_eoi = 1'b0;
          n.tx_poll = 1'b1;
          n.sh = SH_WAIT_RFD;
        end else if (talk_act && !q.spe && q.query_pend && RESP_VALID) begin
          n.tx_byte = RESP_DATA;
          n.tx_eoi = RESP_LAST;
          n.tx_poll = 1'b0;
          n.resp_take = 1'b1;
          n.sh = SH_WAIT_RFD;
        end
        n.dio_oe_n = ~n.tx_byte | {8{n.sh == SH_IDLE}};
        n.eoi_oe_n = ~(n.tx_eoi && n.sh != SH_IDLE);
      end
      SH_WAIT_RFD: begin
        if (q.s2.nrfd_n) begin
          n.dav_oe_n = 1'b0;
          n.sh = SH_DAV;
        end
      end
      SH_DAV: begin
        if (q.s2.ndac_n) begin
          n.dav_oe_n = 1'b1;
          n.dio_oe_n = 8'hFF;
          n.eoi_oe_n = 1'b1;
          n.sh = SH_WAIT_DAC;
          if (q.tx_poll) begin
            n.polled = 1'b1;
            n.stb = n.stb & ~q.tx_byte;
          end
          if (q.tx_eoi) begin
            n.query_pend = 1'b0;
          end
        end
      end
      SH_WAIT_DAC: begin
        if (!q.s2.ndac_n) begin
          n.sh = SH_IDLE;
        end
      end
      default: n.sh = SH_IDLE;
    endcase
    if (!talk_act && q.sh != SH_IDLE) begin
      n.sh = SH_IDLE;
      n.dav_oe_n = 1'b1;
      n.dio_oe_n = 8'hFF;
      n.eoi_oe_n = 1'b1;
    end

    if (!q.s2.ifc_n) begin
      n = clear_io(n, 1'b1);
    end

    // events set after any clear so that a coincident event survives
    if (STATUS_EVENTS.ramp_done) n.stb[STB_RAMP_BIT] = 1'b1;
    if (STATUS_EVENTS.event_summary) n.stb[STB_ESB_BIT] = 1'b1;
    if (STATUS_EVENTS.inst_error) n.stb[STB_ERROR_BIT] = 1'b1;
    if (STATUS_EVENTS.alarm) n.stb[STB_ALARM_BIT] = 1'b1;
    if (STATUS_EVENTS.new_reading) n.stb[STB_NEW_BIT] = 1'b1;
    n.stb = n.stb & STB_EVENT_MASK;

    rqs = n.sre[STB_RQS_BIT] && ((n.stb & n.sre & STB_EVENT_MASK) != 8'h00);
    n.srq_oe_n = ~rqs;
    n.stb_out = n.stb;
    n.stb_out[STB_RQS_BIT] = rqs;
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      q <= '0;
      q.s1 <= '1;
      q.s2 <= '1;
      q.ah <= AH_READY;
      q.sh <= SH_IDLE;
      q.addr <= ADDR_DEFAULT;
      q.term <= TERM_DEFAULT;
      q.stb <= STB_RESET;
      q.sre <= SRE_RESET;
      q.dio_oe_n <= 8'hFF;
      q.dav_oe_n <= 1'b1;
      q.eoi_oe_n <= 1'b1;
      q.nrfd_oe_n <= 1'b1;
      q.ndac_oe_n <= 1'b1;
      q.srq_oe_n <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // open collector: the driven level is always low
  assign DIO_N_O = 8'h00;
  assign DAV_N_O = 1'b0;
  assign EOI_N_O = 1'b0;
  assign NRFD_N_O = 1'b0;
  assign NDAC_N_O = 1'b0;
  assign SRQ_N_O = 1'b0;
  assign DIO_N_OE_N = q.dio_oe_n;
  assign DAV_N_OE_N = q.dav_oe_n;
  assign EOI_N_OE_N = q.eoi_oe_n;
  assign NRFD_N_OE_N = q.nrfd_oe_n;
  assign NDAC_N_OE_N = q.ndac_oe_n;
  assign SRQ_N_OE_N = q.srq_oe_n;
  assign RESP_TAKE = q.resp_take;
  assign MSG_DATA = q.msg_data;
  assign MSG_VALID = q.msg_valid;
  assign MSG_SEP = q.msg_sep;
  assign MSG_QUERY = q.msg_query;
  assign MSG_END = q.msg_end;
  assign MSG_ERR = q.msg_err;
  assign REMOTE = q.remote;
  assign PANEL_LOCKED = q.lockout;
  assign LISTENING = q.listen;
  assign TALKING = q.talk;
  assign BUS_ADDR = q.addr;
  assign STATUS_BYTE = q.stb_out;
  assign SRE_VALUE = q.sre;

endmodule

/* hdl/gpib_msu_pkg.sv */
package gpib_msu_pkg;

  // bus address selection
  localparam logic [4:0] ADDR_DEFAULT = 5'h0C;
  localparam logic [4:0] ADDR_MIN = 5'h01;
  localparam logic [4:0] ADDR_MAX = 5'h1E;

  // message terminator selection
  typedef enum logic [1:0] {
    TERM_CRLF = 2'h0,
    TERM_LFCR = 2'h1,
    TERM_LF = 2'h2,
    TERM_EOI = 2'h3
  } term_t;
  localparam term_t TERM_DEFAULT = TERM_CRLF;

  // message characters
  localparam logic [7:0] CHAR_CR = 8'h0D;
  localparam logic [7:0] CHAR_LF = 8'h0A;
  localparam logic [7:0] CHAR_SEMI = 8'h3B;
  localparam logic [7:0] CHAR_QMARK = 8'h3F;
  localparam logic [7:0] CHAR_SPACE = 8'h20;
  localparam logic [6:0] MSG_MAX_LEN = 7'h40;

  // multiline bus command codes (seven bits, attention asserted)
  localparam logic [6:0] CMD_GTL = 7'h01;
  localparam logic [6:0] CMD_SDC = 7'h04;
  localparam logic [6:0] CMD_LLO = 7'h11;
  localparam logic [6:0] CMD_DCL = 7'h14;
  localparam logic [6:0] CMD_SPE = 7'h18;
  localparam logic [6:0] CMD_SPD = 7'h19;
  localparam logic [6:0] CMD_UNL = 7'h3F;
  localparam logic [6:0] CMD_UNT = 7'h5F;
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK = 2'h2;

  // status byte layout
  localparam int STB_NEW_BIT = 0;
  localparam int STB_ALARM_BIT = 3;
  localparam int STB_ERROR_BIT = 4;
  localparam int STB_ESB_BIT = 5;
  localparam int STB_RQS_BIT = 6;
  localparam int STB_RAMP_BIT = 7;
  localparam logic [7:0] STB_EVENT_MASK = 8'hB9;
  localparam logic [7:0] STB_RESET = 8'h00;
  localparam logic [7:0] SRE_RESET = 8'h00;

  typedef enum {AH_READY, AH_ACCEPT, AH_WAIT_DAV_HIGH} ah_t;
  typedef enum {SH_IDLE, SH_WAIT_RFD, SH_DAV, SH_WAIT_DAC} sh_t;

  typedef struct packed {
    logic ramp_done;
    logic event_summary;
    logic inst_error;
    logic alarm;
    logic new_reading;
  } status_events_t;

  typedef struct packed {
    logic atn_n;
    logic ren_n;
    logic ifc_n;
    logic eoi_n;
    logic dav_n;
    logic nrfd_n;
    logic ndac_n;
    logic [7:0] dio_n;
  } bus_sample_t;

endpackage

/* verification/gpib_ctrl_model.sv */
`timescale 1ns/1ps
module gpib_ctrl_model (
  input wire logic clk,
  input wire logic nrfd_w,
  input wire logic ndac_w,
  input wire logic dav_w,
  input wire logic eoi_w,
  input wire logic [7:0] dio_w,
  output logic atn_n,
  output logic ren_n,
  output logic ifc_n,
  output logic eoi_n,
  output logic dav_n,
  output logic nrfd_n,
  output logic ndac_n,
  output logic [7:0] dio_n
);
  initial begin
    {atn_n, ren_n, ifc_n, eoi_n, dav_n, nrfd_n, ndac_n} = 7'h7F;
    dio_n = 8'hFF;
  end
  function automatic logic lv(input int k);
    return (k == 0) ? nrfd_w : (k == 1) ? ndac_w : dav_w;
  endfunction
  // wait on a settled level, then act on the next rising edge
  task automatic wt(input int k, input logic v);
    @(negedge clk);
    for (int i = 0; i < 300 && lv(k) !== v; i++) @(negedge clk);
    @(posedge clk);
  endtask
  task automatic send(input logic [7:0] b, input logic cmd, input logic last);
    @(posedge clk);
    atn_n <= !cmd;
    ndac_n <= 1'b1;
    dio_n <= ~b;
    eoi_n <= !last;
    // listeners must hold ndac low before data is offered
    wt(1, 1'b0);
    wt(0, 1'b1);
    dav_n <= 1'b0;
    wt(1, 1'b1);
    dav_n <= 1'b1;
    dio_n <= 8'hFF;
    eoi_n <= 1'b1;
    wt(1, 1'b0);
  endtask
  task automatic recv(output logic [7:0] b, output logic e);
    @(posedge clk);
    atn_n <= 1'b1;
    ndac_n <= 1'b0;
    wt(2, 1'b0);
    b = ~dio_w;
    e = !eoi_w;
    nrfd_n <= 1'b0;
    ndac_n <= 1'b1;
    wt(2, 1'b1);
    ndac_n <= 1'b0;
    nrfd_n <= 1'b1;
  endtask
endmodule

/* verification/gpib_message_status_unit_tb_top.sv */
`timescale 1ns/1ps
module gpib_message_status_unit_tb_top;
  import gpib_msu_pkg::*;
  localparam logic [6:0] LA = {GRP_LISTEN, ADDR_DEFAULT};
  localparam logic [6:0] TA = {GRP_TALK, ADDR_DEFAULT};
  logic clk = 1'b0, rst = 1'b1, cfg_wr = 1'b0, sre_wr = 1'b0;
  logic [4:0] cfg_addr = 5'h0C;
  logic [7:0] sre_data = 8'h00;
  term_t cfg_term = TERM_CRLF;
  status_events_t ev = '0;
  logic c_atn, c_ren, c_ifc, c_eoi, c_dav, c_nrfd, c_ndac;
  logic [7:0] c_dio, dio_oe, stb, srev, mdata, mlast;
  logic eoi_oe, dav_oe, nrfd_oe, ndac_oe, srq_oe, rtake, mvalid, msep, mquery, mend, merr;
  logic remote, locked, listening, talking;
  logic [4:0] addr;
  int ri = 2, nv = 0, ns = 0, nq = 0, ne = 0, nr = 0, bad_count = 0, total_checks = 0;
  wire eoi_w = c_eoi & eoi_oe;
  wire dav_w = c_dav & dav_oe;
  wire nrfd_w = c_nrfd & nrfd_oe;
  wire ndac_w = c_ndac & ndac_oe;
  wire [7:0] dio_w = c_dio & dio_oe;
  wire rvalid = (ri < 2);
  wire rlast = (ri == 1);
  wire [7:0] rdata = (ri == 0) ? 8'h4F : 8'h4B;
  initial forever #4 clk = ~clk;
  gpib_message_status_unit dut (
    .MCLK(clk), .RESET(rst), .ATN_N_I(c_atn), .REN_N_I(c_ren), .IFC_N_I(c_ifc),
    .EOI_N_I(eoi_w), .EOI_N_O(), .EOI_N_OE_N(eoi_oe), .DAV_N_I(dav_w), .DAV_N_O(),
    .DAV_N_OE_N(dav_oe), .NRFD_N_I(nrfd_w), .NRFD_N_O(), .NRFD_N_OE_N(nrfd_oe),
    .NDAC_N_I(ndac_w), .NDAC_N_O(), .NDAC_N_OE_N(ndac_oe), .DIO_N_I(dio_w), .DIO_N_O(),
    .DIO_N_OE_N(dio_oe), .SRQ_N_O(), .SRQ_N_OE_N(srq_oe), .CFG_WR(cfg_wr),
    .CFG_ADDR(cfg_addr), .CFG_TERM(cfg_term), .SRE_WR(sre_wr), .SRE_DATA(sre_data),
    .STATUS_EVENTS(ev), .RESP_DATA(rdata), .RESP_VALID(rvalid), .RESP_LAST(rlast),
    .RESP_TAKE(rtake), .MSG_DATA(mdata), .MSG_VALID(mvalid), .MSG_SEP(msep),
    .MSG_QUERY(mquery), .MSG_END(mend), .MSG_ERR(merr), .REMOTE(remote),
    .PANEL_LOCKED(locked), .LISTENING(listening), .TALKING(talking), .BUS_ADDR(addr),
    .STATUS_BYTE(stb), .SRE_VALUE(srev));
  gpib_ctrl_model m (.clk(clk), .nrfd_w(nrfd_w), .ndac_w(ndac_w), .dav_w(dav_w),
    .eoi_w(eoi_w), .dio_w(dio_w), .atn_n(c_atn), .ren_n(c_ren), .ifc_n(c_ifc),
    .eoi_n(c_eoi), .dav_n(c_dav), .nrfd_n(c_nrfd), .ndac_n(c_ndac), .dio_n(c_dio));
  always @(posedge clk) begin
    nv <= nv + int'(mvalid);
    ns <= ns + int'(msep);
    nq <= nq + int'(mquery);
    ne <= ne + int'(mend);
    nr <= nr + int'(merr);
    if (mvalid) mlast <= mdata;
  end
  always @(posedge clk) if (rtake) ri <= ri + 1;
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // leaves the caller at a falling edge, outputs settled
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic cmd(input logic [6:0] c);
    m.send({1'b0, c}, 1'b1, 1'b0);
  endtask
  task automatic txt(input string s);
    for (int i = 0; i < s.len(); i++) m.send(s[i], 1'b0, 1'b0);
  endtask
  task automatic ev_pulse(input logic [4:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= '0;
    cyc(2);
  endtask
  task automatic sre_w(input logic [7:0] v);
    @(posedge clk);
    sre_wr <= 1'b1;
    sre_data <= v;
    @(posedge clk);
    sre_wr <= 1'b0;
    cyc(2);
  endtask
  task automatic cfg_w(input logic [4:0] a, input term_t t);
    @(posedge clk);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_term <= t;
    @(posedge clk);
    cfg_wr <= 1'b0;
    cyc(2);
  endtask
  task automatic t_reset;
    cyc(1);
    chk(8'(addr), 8'h0C);
    chk(stb, 8'h00);
    chk(srev, 8'h00);
    chk(8'(remote), 8'h00);
    $display("reset test done");
  endtask
  task automatic t_remote;
    @(posedge clk);
    m.ren_n <= 1'b0;
    cyc(6);
    chk(8'(remote), 8'h01);
    cmd(CMD_LLO);
    cyc(2);
    chk(8'(locked), 8'h01);
    cmd(CMD_UNL);
    cmd(CMD_GTL);
    cyc(2);
    chk(8'(remote), 8'h01);
    cmd(LA);
    cmd(CMD_GTL);
    cyc(2);
    chk(8'(remote), 8'h00);
    $display("remote test done");
  endtask
  task automatic t_msg;
    int v, s, q, e, r;
    logic [4:0] av[5] = '{5'h00, 5'h01, 5'h1F, 5'h1E, 5'h0C};
    logic [7:0] ex[5] = '{8'h0C, 8'h01, 8'h01, 8'h1E, 8'h0C};
    {v, s, q, e, r} = {nv, ns, nq, ne, nr};
    cmd(LA);
    txt("A 1;B?\r\n");
    cyc(4);
    chk(8'(nv - v), 8'h05);
    chk(8'(ns - s), 8'h02);
    chk(8'(nq - q), 8'h01);
    chk(8'(ne - e), 8'h01);
    chk(8'(nr - r), 8'h00);
    chk(mlast, CHAR_QMARK);
    txt("?\r\n");
    txt("X?;A 1\r\n");
    cyc(4);
    chk(8'(nr - r), 8'h03);
    r = nr;
    repeat (65) m.send(8'h41, 1'b0, 1'b0);
    txt("\r\n");
    cyc(4);
    chk(8'(nr > r), 8'h01);
    for (int t = 0; t < 4; t++) begin
      cfg_w(ADDR_DEFAULT, term_t'(t));
      e = ne;
      case (t)
        0: txt("Z\r\n");
        1: txt("Z\n\r");
        2: txt("Z\n");
        default: m.send(8'h5A, 1'b0, 1'b1);
      endcase
      cyc(4);
      chk(8'(ne - e), 8'h01);
    end
    for (int i = 0; i < 5; i++) begin
      cfg_w(av[i], TERM_CRLF);
      chk(8'(addr), ex[i]);
    end
    $display("message test done");
  endtask
  task automatic t_stat;
    sre_w(8'h41);
    ev_pulse(5'h01);
    chk(stb & 8'hBF, 8'h01);
    chk(8'(srq_oe), 8'h00);
    sre_w(8'h01);
    chk(8'(srq_oe), 8'h01);
    ev_pulse(5'h1F);
    chk(stb & 8'hBF, STB_EVENT_MASK);
    sre_w(8'h40);
    chk(8'(srq_oe), 8'h01);
    sre_w(8'h48);
    chk(8'(srq_oe), 8'h00);
    $display("status test done");
  endtask
  task automatic t_poll;
    logic [7:0] b;
    logic e;
    cyc(10);
    chk(stb & 8'hBF, STB_EVENT_MASK);
    cmd(CMD_SPE);
    cmd(TA);
    m.recv(b, e);
    chk(b, STB_EVENT_MASK | 8'h40);
    chk(8'(talking), 8'h01);
    cmd(CMD_UNT);
    cmd(CMD_SPD);
    cyc(2);
    chk(stb, 8'h00);
    chk(8'(srq_oe), 8'h01);
    $display("poll test done");
  endtask
  task automatic t_query;
    logic [7:0] b;
    logic e;
    cmd(LA);
    txt("X?\r\n");
    txt("Y?\r\n");
    cyc(20);
    chk(8'(dav_oe), 8'h01);
    @(posedge clk);
    ri <= 0;
    cmd(TA);
    m.recv(b, e);
    chk(b, 8'h4F);
    chk(8'(e), 8'h00);
    m.recv(b, e);
    chk(b, 8'h4B);
    chk(8'(e), 8'h01);
    @(posedge clk);
    ri <= 0;
    cyc(40);
    chk(8'(dav_oe), 8'h01);
    cmd(CMD_UNT);
    $display("query test done");
  endtask
  task automatic t_clear;
    ev_pulse(5'h02);
    cmd(CMD_DCL);
    cyc(2);
    chk(stb, 8'h00);
    ev_pulse(5'h02);
    cmd(CMD_UNL);
    cmd(CMD_SDC);
    cyc(2);
    chk(stb & 8'h08, 8'h08);
    cmd(LA);
    cmd(CMD_SDC);
    cyc(2);
    chk(stb, 8'h00);
    chk(8'(listening), 8'h01);
    @(posedge clk);
    m.ifc_n <= 1'b0;
    cyc(8);
    chk(8'(listening), 8'h00);
    @(posedge clk);
    m.ifc_n <= 1'b1;
    $display("clear test done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_remote;
    t_msg;
    t_stat;
    t_poll;
    t_query;
    t_clear;
    stop_test;
  end
  initial begin
    #400000;
    bad_count++;
    stop_test;
  end
endmodule

/* verification/gpib_msu_monitor.sv */
`timescale 1ns/1ps
module gpib_msu_monitor (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic IFC_N_I,
  input wire logic TALKING,
  input wire logic LISTENING,
  input wire logic DAV_N_OE_N,
  input wire logic [7:0] DIO_N_OE_N,
  input wire logic SRQ_N_OE_N,
  input wire logic [4:0] BUS_ADDR,
  input wire logic [7:0] STATUS_BYTE,
  input wire logic [7:0] SRE_VALUE,
  input wire gpib_msu_pkg::status_events_t STATUS_EVENTS
);
  import gpib_msu_pkg::*;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  sequence s_ifc;
    !IFC_N_I [*5];
  endsequence
  sequence s_untalk;
    !TALKING [*2];
  endsequence
  property p_addr; BUS_ADDR >= ADDR_MIN && BUS_ADDR <= ADDR_MAX; endproperty
  a_addr: assert property (p_addr) else $error("address range");
  property p_zero; STATUS_BYTE[2:1] == 2'h0; endproperty
  a_zero: assert property (p_zero) else $error("unused bits set");
  property p_new; STATUS_EVENTS.new_reading |=> STATUS_BYTE[STB_NEW_BIT]; endproperty
  a_new: assert property (p_new) else $error("reading bit");
  property p_alarm; STATUS_EVENTS.alarm |=> STATUS_BYTE[STB_ALARM_BIT]; endproperty
  a_alarm: assert property (p_alarm) else $error("alarm bit");
  property p_gate; !SRE_VALUE[STB_RQS_BIT] [*2] |-> SRQ_N_OE_N; endproperty
  a_gate: assert property (p_gate) else $error("request while gated");
  property p_srq;
    !SRQ_N_OE_N |-> ((STATUS_BYTE | $past(STATUS_BYTE)) & (SRE_VALUE | $past(SRE_VALUE))
      & STB_EVENT_MASK) != 8'h00;
  endproperty
  a_srq: assert property (p_srq) else $error("request without cause");
  property p_quiet; s_untalk |-> DAV_N_OE_N && DIO_N_OE_N == 8'hFF; endproperty
  a_quiet: assert property (p_quiet) else $error("drive while untalked");
  property p_ifc; s_ifc |-> !LISTENING && !TALKING; endproperty
  a_ifc: assert property (p_ifc) else $error("clear ignored");
endmodule

bind gpib_message_status_unit gpib_msu_monitor mon (.*);
